// ==== core/bridge_config_id_status.sv ====
/*
  AHB-Lite register slave for the identification word and the start of
  the command/status word of a PCIe-to-PCI bridge, with event interrupt.
  Assumes event inputs are one-cycle pulses synchronous to hclk and that
  the serial EEPROM loader presents new identifiers with a one-cycle strobe.
*/
// Chosen here: the AHB-Lite slave port.
// Behaviour
// RL1: identification word upper half shows device identifier, read-only.
// RL2: identification word lower half shows vendor identifier, read-only.
// RL3: EEPROM load replaces both identifiers; otherwise built-in defaults stay.
// RL4: parity flag sets on poisoned TLP or bad ECRC, ignoring parity enable.
// RL5: system error flag sets on sent fatal/nonfatal message when enabled.
// RL6: master abort flag sets on unsupported-request completion received.
// RL7: writing zero leaves a flag; set beats a simultaneous clearing write.
`timescale 1ns/1ps
module bridge_config_id_status (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic poisoned_tlp_rx,
  input wire logic bad_ecrc_rx,
  input wire logic err_msg_tx,
  input wire logic ur_cpl_rx,
  input wire logic eeprom_id_load,
  input wire logic [15:0] eeprom_device_identifier,
  input wire logic [15:0] eeprom_vendor_identifier,
  output logic irq
);

  typedef enum logic {ST_RUN, ST_RD_WAIT} rd_state_t;

  rd_state_t state_r, state_nxt;
  logic dp_valid_r, dp_valid_nxt;
  logic dp_write_r, dp_write_nxt;
  logic [11:0] dp_addr_r, dp_addr_nxt;
  logic [31:0] hrdata_r, hrdata_nxt;
  logic hreadyout_r, hreadyout_nxt;
  logic irq_r, irq_nxt;
  logic [15:0] device_identifier_r, device_identifier_nxt;
  logic [15:0] vendor_identifier_r, vendor_identifier_nxt;
  logic system_error_enable_r, system_error_enable_nxt;
  logic parity_error_response_enable_r, parity_error_response_enable_nxt;
  logic [2:0] int_enable_r, int_enable_nxt;

  logic addr_ok;
  logic wr_dp;
  logic wr_csr;
  logic wr_iclr;
  logic [2:0] evt;
  logic [2:0] flag;
  logic [2:0] flag_clr;
  logic [2:0] int_status;
  logic [2:0] int_clr;
  logic [2:0] csr_bit;

  assign hrdata = hrdata_r;
  assign hreadyout = hreadyout_r;
  assign irq = irq_r;

  // ----------------------------------------------------------------------
  // events and sticky flags
  // ----------------------------------------------------------------------
  assign csr_bit[bridge_cfg_pkg::EVT_DPE] = hwdata[bridge_cfg_pkg::DPE_BIT];
  assign csr_bit[bridge_cfg_pkg::EVT_SSE] = hwdata[bridge_cfg_pkg::SSE_BIT];
  assign csr_bit[bridge_cfg_pkg::EVT_RMA] = hwdata[bridge_cfg_pkg::RMA_BIT];

  // parity enable deliberately not consulted here
  assign evt[bridge_cfg_pkg::EVT_DPE] = poisoned_tlp_rx | bad_ecrc_rx; // RL4
  assign evt[bridge_cfg_pkg::EVT_SSE] = err_msg_tx & system_error_enable_r; // RL5
  assign evt[bridge_cfg_pkg::EVT_RMA] = ur_cpl_rx; // RL6

  assign addr_ok = hsel & htrans[1] & hready;
  assign wr_dp = dp_valid_r & dp_write_r;
  assign wr_csr = wr_dp & (dp_addr_r == bridge_cfg_pkg::OFF_CSR_WORD);
  assign wr_iclr = wr_dp & (dp_addr_r == bridge_cfg_pkg::OFF_INT_CLEAR);
  assign flag_clr = wr_csr ? csr_bit : 3'h0; // RL7
  assign int_clr = wr_iclr ? hwdata[2:0] : 3'h0;

  genvar gi;
  generate
    for (gi = 0; gi < bridge_cfg_pkg::NUM_EVT; gi++) begin : g_flag
      // set wins inside the cell
      sticky_flag u_csr_flag (
        .clk(hclk),
        .rst_n(hresetn),
        .set(evt[gi]),
        .clr(flag_clr[gi]),
        .q(flag[gi])
      ); // RL7
      sticky_flag u_int_flag (
        .clk(hclk),
        .rst_n(hresetn),
        .set(evt[gi]),
        .clr(int_clr[gi]),
        .q(int_status[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------------
  // read multiplexer
  // ----------------------------------------------------------------------
  function automatic logic [31:0] rd_mux(input logic [11:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    unique case (a)
      bridge_cfg_pkg::OFF_ID_WORD: begin
        v[bridge_cfg_pkg::DEV_ID_LSB +: 16] = device_identifier_r; // RL1
        v[bridge_cfg_pkg::VEN_ID_LSB +: 16] = vendor_identifier_r; // RL2
      end
      bridge_cfg_pkg::OFF_CSR_WORD: begin
        v = bridge_cfg_pkg::CSR_RESET;
        v[bridge_cfg_pkg::DPE_BIT] = flag[bridge_cfg_pkg::EVT_DPE];
        v[bridge_cfg_pkg::SSE_BIT] = flag[bridge_cfg_pkg::EVT_SSE];
        v[bridge_cfg_pkg::RMA_BIT] = flag[bridge_cfg_pkg::EVT_RMA];
        v[bridge_cfg_pkg::SYSTEM_ERROR_ENABLE_BIT] = system_error_enable_r;
        v[bridge_cfg_pkg::PERR_EN_BIT] = parity_error_response_enable_r;
      end
      bridge_cfg_pkg::OFF_INT_STATUS: begin
        v[2:0] = int_status;
      end
      bridge_cfg_pkg::OFF_INT_ENABLE: begin
        v[2:0] = int_enable_r;
      end
      default: begin
        v = 32'h0000_0000;
      end
    endcase
    return v;
  endfunction

  // ----------------------------------------------------------------------
  // bus slave next state
  // ----------------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    dp_valid_nxt = dp_valid_r;
    dp_write_nxt = dp_write_r;
    dp_addr_nxt = dp_addr_r;
    hrdata_nxt = hrdata_r;
    hreadyout_nxt = 1'b1;
    if (hready) begin
      dp_valid_nxt = addr_ok;
    end
    if (addr_ok) begin
      dp_write_nxt = hwrite;
      dp_addr_nxt = {haddr[11:2], 2'b00};
    end
    unique case (state_r)
      ST_RUN: begin
        if (addr_ok && !hwrite) begin
          // a read behind a write waits one cycle so it sees the written value
          if (wr_dp) begin
            state_nxt = ST_RD_WAIT;
            hreadyout_nxt = 1'b0;
          end else begin
            hrdata_nxt = rd_mux({haddr[11:2], 2'b00});
          end
        end
      end
      ST_RD_WAIT: begin
        hrdata_nxt = rd_mux(dp_addr_r);
        state_nxt = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= ST_RUN;
      dp_valid_r <= 1'b0;
      dp_write_r <= 1'b0;
      dp_addr_r <= 12'h000;
      hrdata_r <= 32'h0000_0000;
      hreadyout_r <= 1'b1;
    end else begin
      state_r <= state_nxt;
      dp_valid_r <= dp_valid_nxt;
      dp_write_r <= dp_write_nxt;
      dp_addr_r <= dp_addr_nxt;
      hrdata_r <= hrdata_nxt;
      hreadyout_r <= hreadyout_nxt;
    end
  end

  // single slave: response is always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // software-visible state next values
  // ----------------------------------------------------------------------
  always_comb begin
    device_identifier_nxt = device_identifier_r;
    vendor_identifier_nxt = vendor_identifier_r;
    system_error_enable_nxt = system_error_enable_r;
    parity_error_response_enable_nxt = parity_error_response_enable_r;
    int_enable_nxt = int_enable_r;
    // identifiers change only by the EEPROM loader, never by bus writes
    if (eeprom_id_load) begin
      device_identifier_nxt = eeprom_device_identifier; // RL3
      vendor_identifier_nxt = eeprom_vendor_identifier; // RL3
    end
    if (wr_csr) begin
      system_error_enable_nxt = hwdata[bridge_cfg_pkg::SYSTEM_ERROR_ENABLE_BIT];
      parity_error_response_enable_nxt = hwdata[bridge_cfg_pkg::PERR_EN_BIT];
    end
    if (wr_dp && dp_addr_r == bridge_cfg_pkg::OFF_INT_ENABLE) begin
      int_enable_nxt = hwdata[2:0];
    end
    irq_nxt = |(int_status_nxt_view() & int_enable_nxt);
  end

  // status as it will stand after this edge, so irq tracks it without lag
  function automatic logic [2:0] int_status_nxt_view();
    return (int_status & ~int_clr) | evt;
  endfunction

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      device_identifier_r <= bridge_cfg_pkg::DEV_ID_DEFAULT;
      vendor_identifier_r <= bridge_cfg_pkg::VEN_ID_DEFAULT;
      system_error_enable_r <= 1'b0;
      parity_error_response_enable_r <= 1'b0;
      int_enable_r <= bridge_cfg_pkg::INT_ENABLE_RESET;
      irq_r <= 1'b0;
    end else begin
      device_identifier_r <= device_identifier_nxt;
      vendor_identifier_r <= vendor_identifier_nxt;
      system_error_enable_r <= system_error_enable_nxt;
      parity_error_response_enable_r <= parity_error_response_enable_nxt;
      int_enable_r <= int_enable_nxt;
      irq_r <= irq_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  logic rd_done;
  assign rd_done = dp_valid_r & ~dp_write_r & hreadyout_r;

  a_id_upper: assert property ( // RL1
    @(posedge hclk) disable iff (!hresetn)
    rd_done && dp_addr_r == bridge_cfg_pkg::OFF_ID_WORD && !$past(eeprom_id_load)
      |-> hrdata_r[31:16] == device_identifier_r)
    else $error("device identifier not in upper half");

  a_id_lower: assert property ( // RL2
    @(posedge hclk) disable iff (!hresetn)
    rd_done && dp_addr_r == bridge_cfg_pkg::OFF_ID_WORD && !$past(eeprom_id_load)
      |-> hrdata_r[15:0] == vendor_identifier_r)
    else $error("vendor identifier not in lower half");

  a_id_load: assert property ( // RL3
    @(posedge hclk) disable iff (!hresetn)
    eeprom_id_load |=> device_identifier_r == $past(eeprom_device_identifier)
      && vendor_identifier_r == $past(eeprom_vendor_identifier))
    else $error("identifiers not replaced by eeprom load");

  a_id_hold: assert property ( // RL3
    @(posedge hclk) disable iff (!hresetn)
    !eeprom_id_load |=> $stable(device_identifier_r) && $stable(vendor_identifier_r))
    else $error("identifier changed without eeprom load");

  a_dpe_set: assert property ( // RL4
    @(posedge hclk) disable iff (!hresetn)
    (poisoned_tlp_rx || bad_ecrc_rx) |=> flag[bridge_cfg_pkg::EVT_DPE] [*2] or
      (flag[bridge_cfg_pkg::EVT_DPE] ##1 $past(flag_clr[bridge_cfg_pkg::EVT_DPE])))
    else $error("detected parity flag not set");

  a_sse_cause: assert property ( // RL5
    @(posedge hclk) disable iff (!hresetn)
    $rose(flag[bridge_cfg_pkg::EVT_SSE]) |-> $past(err_msg_tx && system_error_enable_r))
    else $error("system error flag set without enabled message");

  a_sse_set: assert property ( // RL5
    @(posedge hclk) disable iff (!hresetn)
    err_msg_tx && system_error_enable_r |=> flag[bridge_cfg_pkg::EVT_SSE])
    else $error("system error flag not set");

  a_rma_set: assert property ( // RL6
    @(posedge hclk) disable iff (!hresetn)
    ur_cpl_rx |=> flag[bridge_cfg_pkg::EVT_RMA])
    else $error("master abort flag not set");

  a_w1c_zero: assert property ( // RL7
    @(posedge hclk) disable iff (!hresetn)
    wr_csr && !hwdata[bridge_cfg_pkg::DPE_BIT] && flag[bridge_cfg_pkg::EVT_DPE]
      |=> flag[bridge_cfg_pkg::EVT_DPE])
    else $error("zero write cleared a flag");

  a_w1c_clear: assert property ( // RL7
    @(posedge hclk) disable iff (!hresetn)
    wr_csr && hwdata[bridge_cfg_pkg::RMA_BIT] && !ur_cpl_rx |=> !flag[bridge_cfg_pkg::EVT_RMA])
    else $error("one write did not clear flag");

  a_irq_level: assert property (
    @(posedge hclk) disable iff (!hresetn)
    irq_r == |(int_status & int_enable_r))
    else $error("interrupt level disagrees with status");

endmodule

// ==== core/bridge_cfg_pkg.sv ====
/*
  Package for the bridge configuration identification and status block:
  register offsets, field positions, reset values and built-in identifiers.
  Assumes a 32-bit AHB-Lite register bus with word-aligned registers.
*/
package bridge_cfg_pkg;

  // ----------------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [11:0] OFF_ID_WORD = 12'h000;
  localparam logic [11:0] OFF_CSR_WORD = 12'h004;
  localparam logic [11:0] OFF_INT_STATUS = 12'h008;
  localparam logic [11:0] OFF_INT_CLEAR = 12'h00C;
  localparam logic [11:0] OFF_INT_ENABLE = 12'h010;
  localparam int ADDR_W = 12;

  // ----------------------------------------------------------------------
  // identification word fields
  // ----------------------------------------------------------------------
  localparam int DEV_ID_LSB = 16;
  localparam int VEN_ID_LSB = 0;
  // arbitrary built-in identifiers, not tied to any real part
  localparam logic [15:0] DEV_ID_DEFAULT = 16'hA5C3;
  localparam logic [15:0] VEN_ID_DEFAULT = 16'h1F2E;

  // ----------------------------------------------------------------------
  // command / status word fields
  // ----------------------------------------------------------------------
  localparam int DPE_BIT = 31;
  localparam int SSE_BIT = 30;
  localparam int RMA_BIT = 29;
  localparam int CAP_LIST_BIT = 20;
  localparam int SYSTEM_ERROR_ENABLE_BIT = 8;
  localparam int PERR_EN_BIT = 6;
  localparam logic [31:0] CSR_RESET = 32'h0010_0000;

  // ----------------------------------------------------------------------
  // interrupt status / clear / enable layout
  // ----------------------------------------------------------------------
  localparam int NUM_EVT = 3;
  localparam int EVT_DPE = 0;
  localparam int EVT_SSE = 1;
  localparam int EVT_RMA = 2;
  localparam logic [2:0] INT_ENABLE_RESET = 3'h0;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

endpackage

// ==== core/sticky_flag.sv ====
/*
  One sticky status flag: set by a hardware event, cleared by a strobe.
  Assumes set and clear are synchronous to clk; set wins over clear.
*/
`timescale 1ns/1ps
module sticky_flag (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic set,
  input wire logic clr,
  output logic q
);

  logic q_nxt;

  // ----------------------------------------------------------------------
  // next value
  // ----------------------------------------------------------------------
  always_comb begin
    q_nxt = q;
    if (clr) begin
      q_nxt = 1'b0;
    end
    // an event in the clearing cycle is never lost
    if (set) begin
      q_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= 1'b0;
    end else begin
      q <= q_nxt;
    end
  end

endmodule

// ==== tb/pcie_side_model.sv ====
/*
  Far side of the bridge: PCIe link events and the serial EEPROM loader.
  Assumes fire is called right after a rising edge of hclk.
*/
`timescale 1ns/1ps
module pcie_side_model (
  input wire logic hclk,
  output logic poisoned_tlp_rx,
  output logic bad_ecrc_rx,
  output logic err_msg_tx,
  output logic ur_cpl_rx,
  output logic eeprom_id_load,
  output logic [15:0] eeprom_device_identifier,
  output logic [15:0] eeprom_vendor_identifier
);
  initial begin
    {eeprom_id_load, ur_cpl_rx, err_msg_tx, bad_ecrc_rx, poisoned_tlp_rx} = 5'h00;
    {eeprom_device_identifier, eeprom_vendor_identifier} = 32'h0;
  end
  // ----------------------------------------------------------------------
  // one-cycle event pulses
  // ----------------------------------------------------------------------
  // ids inverted after a load so a stale value never passes
  task automatic fire(input logic [4:0] m, input logic [31:0] ids);
    {eeprom_id_load, ur_cpl_rx, err_msg_tx, bad_ecrc_rx, poisoned_tlp_rx} <= m;
    {eeprom_device_identifier, eeprom_vendor_identifier} <= ids;
    @(posedge hclk);
    {eeprom_id_load, ur_cpl_rx, err_msg_tx, bad_ecrc_rx, poisoned_tlp_rx} <= 5'h00;
    {eeprom_device_identifier, eeprom_vendor_identifier} <= ~ids;
  endtask
endmodule

// ==== tb/tb.sv ====
/*
  Self-checking bench for the identification and status register block.
  Assumes one AHB-Lite slave, so hready is the slave's own hreadyout.
*/
`timescale 1ns/1ps
module tb;
  localparam logic [31:0] ID_DEF = {bridge_cfg_pkg::DEV_ID_DEFAULT, bridge_cfg_pkg::VEN_ID_DEFAULT};
  localparam logic [31:0] CSR0 = bridge_cfg_pkg::CSR_RESET;
  localparam logic [11:0] A_ID = bridge_cfg_pkg::OFF_ID_WORD;
  localparam logic [11:0] A_CSR = bridge_cfg_pkg::OFF_CSR_WORD;
  localparam logic [11:0] A_ST = bridge_cfg_pkg::OFF_INT_STATUS;
  localparam logic [11:0] A_CLR = bridge_cfg_pkg::OFF_INT_CLEAR;
  localparam logic [11:0] A_EN = bridge_cfg_pkg::OFF_INT_ENABLE;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [11:0] haddr = 12'h000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, irq, ptlp, ecrc, emsg, ucpl, ldid;
  logic [15:0] edev, even;
  logic [31:0] exp_q[$];
  logic rd_pend = 1'b0;
  logic [31:0] r, csr_e;
  logic [31:0] flag_b [4] = '{32'h8000_0000, 32'h8000_0000, 32'h4000_0000, 32'h2000_0000};
  logic [31:0] st_b [4] = '{32'h1, 32'h1, 32'h2, 32'h4};
  integer seed = 32'hedad088a;
  int failures = 0;
  int total_checks = 0;
  int cycles = 0;

  always #5 hclk = ~hclk;

  bridge_config_id_status u_bridge_config_id_status (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .poisoned_tlp_rx(ptlp), .bad_ecrc_rx(ecrc),
    .err_msg_tx(emsg), .ur_cpl_rx(ucpl), .eeprom_id_load(ldid), .eeprom_device_identifier(edev),
    .eeprom_vendor_identifier(even), .irq(irq));

  pcie_side_model u_pcie_side_model (.hclk(hclk), .poisoned_tlp_rx(ptlp), .bad_ecrc_rx(ecrc),
    .err_msg_tx(emsg), .ur_cpl_rx(ucpl), .eeprom_id_load(ldid), .eeprom_device_identifier(edev),
    .eeprom_vendor_identifier(even));

  // ----------------------------------------------------------------------
  // compare, report and bus tasks
  // ----------------------------------------------------------------------
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic wait_rdy;
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask
  task automatic addr(input logic w, input logic [11:0] a);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= bridge_cfg_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    wait_rdy();
  endtask
  task automatic idle;
    hsel <= 1'b0;
    htrans <= 2'h0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    addr(1'b1, a);
    idle();
    hwdata <= d;
    wait_rdy();
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    addr(1'b0, a);
    idle();
    wait_rdy();
  endtask
  // read address overlaps the write data phase: the stall case
  task automatic wr_rd(input logic [11:0] a, input logic [31:0] d, input logic [11:0] ra, input logic [31:0] e);
    addr(1'b1, a);
    hwdata <= d;
    exp_q.push_back(e);
    addr(1'b0, ra);
    idle();
    wait_rdy();
  endtask

  // ----------------------------------------------------------------------
  // read data monitor and timeout
  // ----------------------------------------------------------------------
  always @(posedge hclk) begin
    if (rd_pend && hreadyout === 1'b1 && exp_q.size() > 0) begin
      cmp(hrdata, exp_q.pop_front());
      cmp({31'h0, hresp}, 32'h0);
    end
    if (hreadyout === 1'b1) begin
      rd_pend <= hsel && htrans[1] && !hwrite;
    end
  end
  // whole run is under 400 cycles; generous margin
  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      failures++;
      end_of_test();
    end
  end

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(A_ID, ID_DEF);
    rd(A_CSR, CSR0);
    rd(A_EN, 32'h0);
    rd(12'h020, 32'h0);
    r = $random(seed);
    wr_rd(A_ID, r, A_ID, ID_DEF);
    $display("test reset_and_readonly done");
    r = $random(seed);
    u_pcie_side_model.fire(5'h10, r);
    rd(A_ID, r);
    $display("test eeprom_load done");
    u_pcie_side_model.fire(5'h04, r);
    rd(A_CSR, CSR0);
    wr(A_EN, 32'h7);
    wr(A_CLR, 32'h7);
    csr_e = CSR0 | 32'h100;
    wr(A_CSR, 32'h100);
    for (int k = 0; k < 4; k++) begin
      u_pcie_side_model.fire(5'h01 << k, $random(seed));
      rd(A_CSR, csr_e | flag_b[k]);
      rd(A_ST, st_b[k]);
      cmp({31'h0, irq}, 32'h1);
      wr(A_CSR, 32'h100);
      rd(A_CSR, csr_e | flag_b[k]);
      wr(A_CSR, flag_b[k] | 32'h100);
      rd(A_CSR, csr_e);
      wr(A_CLR, 32'h7);
      rd(A_ST, 32'h0);
      cmp({31'h0, irq}, 32'h0);
    end
    $display("test event_flags done");
    fork
      wr(A_CSR, 32'h2000_0100);
      begin
        @(posedge hclk);
        u_pcie_side_model.fire(5'h08, 32'h0);
      end
    join
    rd(A_CSR, csr_e | 32'h2000_0000);
    wr(A_CSR, 32'h2000_0100);
    wr(A_CLR, 32'h7);
    wr(A_EN, 32'h0);
    u_pcie_side_model.fire(5'h01, 32'h0);
    rd(A_ST, 32'h1);
    rd(A_CLR, 32'h0);
    cmp({31'h0, irq}, 32'h0);
    $display("test set_wins_and_mask done");
    wr(A_CSR, 32'h8000_0140);
    rd(A_CSR, CSR0 | 32'h0000_0140);
    u_pcie_side_model.fire(5'h02, $random(seed));
    rd(A_CSR, CSR0 | 32'h8000_0140);
    $display("test parity_enable_set done");
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(A_ID, ID_DEF);
    rd(A_CSR, CSR0);
    rd(A_ST, 32'h0);
    cmp({31'h0, irq}, 32'h0);
    $display("test mid_run_reset done");
    repeat (2) @(posedge hclk);
    end_of_test();
  end
endmodule
